// [core/cwd_pkg.sv]
package cwd_pkg;
    localparam logic [13:0] CWD_CFG_ADDR = 14'h2007;
    localparam logic [13:0] CWD_TEST_LO = 14'h2000;
    localparam logic [13:0] CWD_TEST_HI = 14'h3fff;
    localparam logic [13:0] CWD_ERASED = 14'h3fff;
    localparam int CWD_OSC_LSB = 0;
    localparam int CWD_WDT_POS = 2;
    localparam int CWD_POWER_UP_DELAY_TIMER_POS = 3;
    localparam int CWD_CP_LSB = 4;
    localparam int CWD_BOR_POS = 6;
    localparam int CLK_MHZ = 250;
    localparam int POWER_UP_DELAY_TIMER_MS = 72;
    localparam int POWER_UP_DELAY_TIMER_CYC = POWER_UP_DELAY_TIMER_MS * 1000 * CLK_MHZ;
    localparam int OST_CYC = 1024;
    localparam int WDT_CYC = 4096;
    typedef enum logic [1:0] {
        CWD_OSC_LP = 2'b00,
        CWD_OSC_XT = 2'b01,
        CWD_OSC_HS = 2'b10,
        CWD_OSC_RC = 2'b11
    } cwd_osc_t;
    typedef enum logic [1:0] {
        CWD_CP_ALL = 2'b00,
        CWD_CP_Q3 = 2'b01,
        CWD_CP_HALF = 2'b10,
        CWD_CP_OFF = 2'b11
    } cwd_cp_t;
    typedef struct packed {
        cwd_cp_t code_protect_select;
        logic brownout_reset_enable;
        logic power_delay_timer_enable;
        logic watchdog_enable_bit;
        cwd_osc_t oscillator_mode_select;
    } cwd_cfg_t;
    typedef enum logic [1:0] {
        CWD_ST_POR = 2'b00,
        CWD_ST_POWER_UP_DELAY_TIMER = 2'b01,
        CWD_ST_OST = 2'b10,
        CWD_ST_RUN = 2'b11
    } cwd_st_t;
endpackage : cwd_pkg

// [core/cwd_cfg_mem.sv]
`timescale 1ns/1ps
module cwd_cfg_mem import cwd_pkg::*; (
    input wire logic sys_clk, // clock
    input wire logic rst_b, // async reset
    input wire logic ce, // clock enable
    input wire logic wr_en, // program pulse
    input wire logic [13:0] wr_data, // word to program
    output logic [13:0] rd_data // stored word
);
    logic [13:0] word_q;
    // programming can only clear bits; erased reads all ones
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            word_q <= CWD_ERASED;
        end else if (ce && wr_en) begin
            word_q <= word_q & wr_data;
        end
    end
    assign rd_data = word_q;
endmodule : cwd_cfg_mem

// [core/cwd_config_word_decoder.sv]
`timescale 1ns/1ps
module cwd_config_word_decoder import cwd_pkg::*; #(
    parameter int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_CYC
) (
    input wire logic sys_clk, // clock
    input wire logic rst_b, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic power_on, // reset is a power-on reset
    input wire logic prog_mode, // programming mode pin
    input wire logic prog_wr, // program strobe
    input wire logic [13:0] prog_addr, // programming address
    input wire logic [13:0] prog_wdata, // programming data
    input wire logic osc_stable, // crystal oscillator running, async
    input wire logic wdt_rc_tick, // watchdog rc oscillator, async
    input wire logic wdt_clear, // clear watchdog instruction
    input wire logic sleep_req, // sleep instruction
    input wire logic ext_reset, // external reset request, async
    input wire logic irq_pending, // interrupt pending
    output logic [13:0] prog_rdata, // programming read data
    output cwd_cfg_t cfg_q, // decoded settings
    output logic core_reset_q, // core held in reset
    output logic sleeping_q, // sleep state
    output logic wdt_timeout_q, // watchdog timeout pulse
    output logic [1:0] protect_q // protection level code, 0 off to 3 all
);
    logic [13:0] word;
    logic cfg_hit;
    logic [2:0] osc_s_q, rc_s_q, ext_s_q;
    logic osc_ok_q, rc_lvl_q, ext_lvl_q, rc_prev_q;
    logic por_q;
    cwd_st_t st_q;
    logic [31:0] cnt_q;
    logic [12:0] wdt_cnt_q;
    logic rc_edge, wdt_fire;

    function automatic logic in_test(input logic [13:0] a);
        in_test = (a >= CWD_TEST_LO) && (a <= CWD_TEST_HI);
    endfunction : in_test

    assign cfg_hit = prog_mode && prog_wr && (prog_addr == CWD_CFG_ADDR);

    cwd_cfg_mem u_mem (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ce(ce),
        .wr_en(cfg_hit),
        .wr_data(prog_wdata),
        .rd_data(word)
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_rdata <= 14'h0000;
        end else if (ce) begin
            if (prog_mode && in_test(prog_addr) && prog_addr == CWD_CFG_ADDR) begin
                prog_rdata <= word;
            end else begin
                prog_rdata <= 14'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_s_q <= 3'h0;
            rc_s_q <= 3'h0;
            ext_s_q <= 3'h0;
            osc_ok_q <= 1'b0;
            rc_lvl_q <= 1'b0;
            ext_lvl_q <= 1'b0;
            rc_prev_q <= 1'b0;
        end else if (ce) begin
            osc_s_q <= {osc_s_q[1:0], osc_stable};
            rc_s_q <= {rc_s_q[1:0], wdt_rc_tick};
            ext_s_q <= {ext_s_q[1:0], ext_reset};
            if (osc_s_q[1] == osc_s_q[2]) osc_ok_q <= osc_s_q[2];
            if (rc_s_q[1] == rc_s_q[2]) rc_lvl_q <= rc_s_q[2];
            if (ext_s_q[1] == ext_s_q[2]) ext_lvl_q <= ext_s_q[2];
            rc_prev_q <= rc_lvl_q;
        end
    end
    assign rc_edge = rc_lvl_q && !rc_prev_q;

    // decoded word straight from the stored bits, not from any run-time control
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= cwd_cfg_t'(7'h7f);
            protect_q <= 2'h0;
        end else if (ce) begin
            cfg_q.oscillator_mode_select <= cwd_osc_t'(word[CWD_OSC_LSB +: 2]);
            cfg_q.watchdog_enable_bit <= word[CWD_WDT_POS];
            cfg_q.power_delay_timer_enable <= word[CWD_POWER_UP_DELAY_TIMER_POS];
            cfg_q.brownout_reset_enable <= word[CWD_BOR_POS];
            cfg_q.code_protect_select <= cwd_cp_t'(word[CWD_CP_LSB +: 2]);
            case (cwd_cp_t'(word[CWD_CP_LSB +: 2]))
                CWD_CP_OFF: protect_q <= 2'h0;
                CWD_CP_HALF: protect_q <= 2'h1;
                CWD_CP_Q3: protect_q <= 2'h2;
                default: protect_q <= 2'h3;
            endcase
        end
    end

    // start-up sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= CWD_ST_POR;
            cnt_q <= 32'h0;
            por_q <= 1'b0;
            core_reset_q <= 1'b1;
        end else if (ce) begin
            if (ext_lvl_q || wdt_fire) begin
                st_q <= CWD_ST_OST;
                cnt_q <= 32'h0;
                core_reset_q <= 1'b1;
            end else begin
                case (st_q)
                    CWD_ST_POR: begin
                        por_q <= power_on;
                        cnt_q <= 32'h0;
                        // power-up delay only for power-on reset
                        if (power_on && word[CWD_POWER_UP_DELAY_TIMER_POS]) st_q <= CWD_ST_POWER_UP_DELAY_TIMER;
                        else st_q <= CWD_ST_OST;
                    end
                    CWD_ST_POWER_UP_DELAY_TIMER: begin
                        if (cnt_q >= 32'(POWER_UP_DELAY_TIMER_CYCLES - 1)) begin
                            st_q <= CWD_ST_OST;
                            cnt_q <= 32'h0;
                        end else begin
                            cnt_q <= cnt_q + 32'h1;
                        end
                    end
                    CWD_ST_OST: begin
                        if (!osc_ok_q) begin
                            cnt_q <= 32'h0;
                        end else if (cnt_q >= 32'(OST_CYC - 1)) begin
                            st_q <= CWD_ST_RUN;
                            core_reset_q <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q + 32'h1;
                        end
                    end
                    default: core_reset_q <= 1'b0;
                endcase
            end
        end
    end

    assign wdt_fire = word[CWD_WDT_POS] && rc_edge && wdt_cnt_q == 13'(WDT_CYC - 1);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wdt_cnt_q <= 13'h0;
            wdt_timeout_q <= 1'b0;
        end else if (ce) begin
            wdt_timeout_q <= wdt_fire;
            if (!word[CWD_WDT_POS] || wdt_clear || wdt_fire) begin
                wdt_cnt_q <= 13'h0;
            end else if (rc_edge) begin
                wdt_cnt_q <= wdt_cnt_q + 13'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleeping_q <= 1'b0;
        end else if (ce) begin
            if (ext_lvl_q || wdt_fire || irq_pending) begin
                sleeping_q <= 1'b0;
            end else if (sleep_req && st_q == CWD_ST_RUN) begin
                sleeping_q <= 1'b1;
            end
        end
    end

    wake_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && sleeping_q && irq_pending |=> !sleeping_q) else $error("sleep not left");
    wdt_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && !word[CWD_WDT_POS] |=> wdt_cnt_q == 13'h0) else $error("watchdog ran disabled");
    reset_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        st_q != CWD_ST_RUN |-> core_reset_q) else $error("reset released early");
    osc_map_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce |=> cfg_q.oscillator_mode_select == $past(word[1:0])) else $error("osc decode");
    prot_all_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && word[5:4] == 2'b00 |=> protect_q == 2'h3) else $error("protect decode");
    prog_only_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && !prog_mode |=> prog_rdata == 14'h0000) else $error("config read outside");
    power_up_delay_timer_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && st_q == CWD_ST_POR && !power_on && !ext_lvl_q && !wdt_fire
        |=> st_q == CWD_ST_OST) else $error("delay on non-power-up");
    erase_one_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ce && cfg_hit |=> (word & ~$past(word)) == 14'h0000) else $error("bit set");
endmodule : cwd_config_word_decoder

// [verification/cwd_prog_model.sv]
`timescale 1ns/1ps
module cwd_prog_model (
    input wire logic sys_clk, // clock
    output logic prog_mode, // programming mode
    output logic prog_wr, // program strobe
    output logic [13:0] prog_addr, // address
    output logic [13:0] prog_wdata // data
);
    initial begin
        prog_mode = 1'b0;
        prog_wr = 1'b0;
        prog_addr = 14'h0000;
        prog_wdata = 14'h0000;
    end
    // one program pulse, data bus scrambled once released
    task automatic burn(input logic m, input logic [13:0] a, input logic [13:0] d);
        @(posedge sys_clk);
        prog_mode <= m;
        prog_addr <= a;
        prog_wdata <= d;
        prog_wr <= 1'b1;
        @(posedge sys_clk);
        prog_wr <= 1'b0;
        prog_wdata <= ~d;
    endtask : burn
    task automatic peek(input logic m);
        @(posedge sys_clk);
        prog_mode <= m;
        prog_addr <= 14'h2007;
        repeat (3) @(posedge sys_clk);
    endtask : peek
endmodule : cwd_prog_model

// [verification/cwd_config_word_decoder_tb.sv]
`timescale 1ns/1ps
module cwd_config_word_decoder_tb import cwd_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic power_on = 1'b1;
    logic osc_stable = 1'b1;
    logic wdt_rc_tick = 1'b0;
    logic wdt_clear = 1'b0;
    logic sleep_req = 1'b0;
    logic irq_pending = 1'b0;
    logic ce = 1'b1;
    logic ext_reset = 1'b0;
    logic prog_mode, prog_wr, core_reset_q, sleeping_q, wdt_timeout_q;
    logic [13:0] prog_addr, prog_wdata, prog_rdata, w;
    logic [1:0] protect_q;
    cwd_cfg_t cfg_q;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    int hits;
    initial forever #2 sys_clk = ~sys_clk;
    cwd_config_word_decoder #(.POWER_UP_DELAY_TIMER_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .ce(ce), .power_on(power_on), .prog_mode(prog_mode), .prog_wr(prog_wr),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata), .osc_stable(osc_stable),
        .wdt_rc_tick(wdt_rc_tick), .wdt_clear(wdt_clear), .sleep_req(sleep_req),
        .ext_reset(ext_reset), .irq_pending(irq_pending), .prog_rdata(prog_rdata),
        .cfg_q(cfg_q), .core_reset_q(core_reset_q), .sleeping_q(sleeping_q),
        .wdt_timeout_q(wdt_timeout_q), .protect_q(protect_q));
    cwd_prog_model prg (.sys_clk(sys_clk), .prog_mode(prog_mode), .prog_wr(prog_wr),
        .prog_addr(prog_addr), .prog_wdata(prog_wdata));
    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        checked++;
        if (e !== g) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            errors++;
            test_done();
        end
    end
    task automatic do_reset;
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask : do_reset
    task automatic wait_run;
        n = 0;
        while (core_reset_q !== 1'b0 && n < 5000) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_run
    task automatic ticks(input int cnt);
        hits = 0;
        repeat (cnt) begin
            wdt_rc_tick <= ~wdt_rc_tick;
            repeat (4) begin
                @(posedge sys_clk);
                if (wdt_timeout_q === 1'b1) hits++;
            end
        end
    endtask : ticks
    task automatic t_reset;
        do_reset();
        @(posedge sys_clk);
        chk("cfg_erased", 14'h007f, 14'(cfg_q));
        chk("protect_rst", 14'h0000, 14'(protect_q));
        chk("core_rst", 14'h0001, 14'(core_reset_q));
    endtask : t_reset
    task automatic t_start;
        osc_stable <= 1'b0;
        do_reset();
        repeat (1500) @(posedge sys_clk);
        chk("ost_hold", 14'h0001, 14'(core_reset_q));
        osc_stable <= 1'b1;
        wait_run();
        chk("ost_len", 14'h0001, 14'(n >= OST_CYC && n < OST_CYC + 20));
        do_reset();
        wait_run();
        chk("power_up_delay_timer_len", 14'h0001, 14'(n >= OST_CYC + 20 && n < 5000));
        power_on <= 1'b0;
        do_reset();
        wait_run();
        chk("no_power_up_delay_timer", 14'h0001, 14'(n >= OST_CYC && n < OST_CYC + 20));
        power_on <= 1'b1;
    endtask : t_start
    task automatic t_decode;
        for (int i = 0; i < 4; i++) begin
            do_reset();
            w = 14'h3fcc | 14'(i << 4) | 14'(i);
            prg.burn(1'b1, 14'h2007, w);
            repeat (3) @(posedge sys_clk);
            chk("cfg", {7'h00, 2'(i), 3'b111, 2'(i)}, 14'(cfg_q));
            chk("protect", 14'(3 - i), 14'(protect_q));
            prg.peek(1'b1);
            chk("rdata", w, prog_rdata);
        end
    endtask : t_decode
    task automatic t_refuse;
        do_reset();
        prg.burn(1'b0, 14'h2007, 14'h0000);
        prg.burn(1'b1, 14'h2006, 14'h0000);
        repeat (3) @(posedge sys_clk);
        chk("cfg_kept", 14'h007f, 14'(cfg_q));
        prg.peek(1'b0);
        chk("rd_locked", 14'h0000, prog_rdata);
        prg.peek(1'b1);
        chk("rd_erased", 14'h3fff, prog_rdata);
    endtask : t_refuse
    task automatic t_wdt;
        do_reset();
        wait_run();
        ticks(2 * WDT_CYC + 40);
        chk("wdt_fires", 14'h0001, 14'(hits > 0));
        prg.burn(1'b1, 14'h2007, 14'h3ffb);
        wdt_clear <= 1'b1;
        @(posedge sys_clk);
        wdt_clear <= 1'b0;
        ticks(2 * WDT_CYC + 40);
        chk("wdt_off", 14'h0000, 14'(hits));
    endtask : t_wdt
    task automatic t_sleep;
        do_reset();
        wait_run();
        sleep_req <= 1'b1;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("asleep", 14'h0001, 14'(sleeping_q));
        irq_pending <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("woken", 14'h0000, 14'(sleeping_q));
        irq_pending <= 1'b0;
    endtask : t_sleep
    // clock enable low freezes everything, then an external reset wakes and re-times
    task automatic t_ext;
        do_reset();
        wait_run();
        sleep_req <= 1'b1;
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        ce <= 1'b0;
        ext_reset <= 1'b1;
        prg.burn(1'b1, 14'h2007, 14'h3fb7);
        repeat (8) @(posedge sys_clk);
        chk("ce_hold", 14'h0001, 14'(sleeping_q));
        chk("ce_cfg", 14'h007f, 14'(cfg_q));
        ce <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("ext_wake", 14'h0000, 14'(sleeping_q));
        chk("ext_hold", 14'h0001, 14'(core_reset_q));
        ext_reset <= 1'b0;
        prg.burn(1'b1, 14'h2007, 14'h3fb7);
        wait_run();
        chk("ext_no_power_up_delay_timer", 14'h0001, 14'(n >= OST_CYC && n < OST_CYC + 20));
        chk("cfg_bits", 14'h0067, 14'(cfg_q));
    endtask : t_ext
    initial begin
        t_reset();
        t_start();
        t_decode();
        t_refuse();
        t_sleep();
        t_ext();
        t_wdt();
        test_done();
    end
endmodule : cwd_config_word_decoder_tb
